/* File: src/tmc_pkg.sv */
// Package: register map, control layout, modes and decode helpers of timer two
`default_nettype none

package tmc_pkg;

  // ****************************************
  // Register map (byte addresses, APB)
  // ****************************************
  localparam int          TMC_ADDR_W      = 8;
  localparam logic [7:0]  TMC_ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  TMC_ADDR_COUNT  = 8'h04;
  localparam logic [7:0]  TMC_ADDR_CAP    = 8'h08;
  localparam logic [7:0]  TMC_ADDR_IEN    = 8'h0C;

  // ****************************************
  // Widths, field positions and reset values
  // ****************************************
  localparam int           TMC_CNT_W      = 16;
  localparam int           TMC_CTRL_W     = 8;
  localparam int           TMC_IEN_BIT    = 0;
  localparam int           TMC_OVF_BIT    = 7;
  localparam int           TMC_EXF_BIT    = 6;
  localparam logic [15:0]  TMC_CNT_MAX    = 16'hFFFF;
  localparam logic [15:0]  TMC_CNT_ONE    = 16'h0001;
  localparam logic [15:0]  TMC_CNT_RST    = 16'h0000;
  localparam logic [15:0]  TMC_CAP_RST    = 16'h0000;
  localparam logic         TMC_IEN_RST    = 1'b0;
  localparam logic [31:0]  TMC_RDATA_RST  = 32'h0000_0000;
  localparam logic [2:0]   TMC_SYNC_RST   = 3'h7;

  // Bit 7 down to bit 0 of the control word
  typedef struct packed {
    logic ovf;
    logic exf;
    logic rx_clk;
    logic tx_clk;
    logic ext_en;
    logic run;
    logic tcs;
    logic crs;
  } tmc_ctrl_t;

  localparam tmc_ctrl_t TMC_CTRL_RST = tmc_ctrl_t'(8'h00);

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tmc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tmc_apb_rsp_t;

  typedef enum logic [3:0] {
    TMC_OFF     = 4'h1,
    TMC_RELOAD  = 4'h2,
    TMC_CAPTURE = 4'h4,
    TMC_BAUD    = 4'h8
  } tmc_mode_t;

  function automatic tmc_mode_t tmc_mode(input tmc_ctrl_t c);
    tmc_mode_t m;
    m = TMC_OFF;
    if (!c.run) begin
      m = TMC_OFF;
    end else if (c.rx_clk || c.tx_clk) begin
      m = TMC_BAUD;
    end else if (c.crs) begin
      m = TMC_CAPTURE;
    end else begin
      m = TMC_RELOAD;
    end
    return m;
  endfunction

  function automatic logic tmc_is_mapped(input logic [7:0] a);
    return (a == TMC_ADDR_CTRL) || (a == TMC_ADDR_COUNT) || (a == TMC_ADDR_CAP) || (a == TMC_ADDR_IEN);
  endfunction

endpackage

`default_nettype wire

/* File: src/tmc_fall_sync.sv */
// Module: three-stage pin synchroniser with agreed falling-edge pulse
`default_nettype none

module tmc_fall_sync (
  input  wire logic sys_clk_i,
  input  wire logic rst_b_i,
  input  wire logic pin_i,
  output var  logic fall_o
);

  logic [2:0] sync_q;
  logic       level_q;

  // Idle high, so release from reset gives no false edge
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      sync_q <= tmc_pkg::TMC_SYNC_RST;
    end else begin
      sync_q <= {sync_q[1:0], pin_i};
    end
  end

  // Last level that stages two and three agreed on
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      level_q <= tmc_pkg::TMC_SYNC_RST[2];
    end else if (sync_q[2] == sync_q[1]) begin
      level_q <= sync_q[2];
    end
  end

  // Stage one only feeds stage two; a fall counts once two and three agree low
  assign fall_o = level_q & ~sync_q[2] & ~sync_q[1];

endmodule

`default_nettype wire

/* File: src/tmc_timer2.sv */
// Module: timer two with mode select, capture, auto-reload and APB registers
//
// Local design decisions: the register offsets and the APB register port.
`default_nettype none

// What this block does
// - Sixteen-bit counter of ticks or external events
// - Run, clock selects and capture select pick mode
// - Capture mode overflow sets the overflow flag
// - Overflow requests interrupt only when enabled
// - Trigger fall copies count into capture register in capture mode
// - Trigger fall also sets external event flag
// - Interrupt request is OR of both flags
// - Auto-reload overflow sets flag and reloads count
// - Baud mode overflow reloads without overflow flag
module tmc_timer2 (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_b_i,
  input  wire tmc_pkg::tmc_apb_req_t apb_i,
  output var  tmc_pkg::tmc_apb_rsp_t apb_o,
  input  wire logic                  event_pin_i,
  input  wire logic                  trigger_input_pin_i,
  output var  logic                  irq_o
);

  // ****************************************
  // State
  // ****************************************
  tmc_pkg::tmc_ctrl_t  ctrl_q;
  tmc_pkg::tmc_ctrl_t  ctrl_d;
  logic [15:0]         count_q;
  logic [15:0]         cap_q;
  logic                ien_q;
  logic [31:0]         prdata_q;
  logic [31:0]         prdata_d;
  tmc_pkg::tmc_mode_t  mode;

  logic ev_fall;
  logic trig_fall;
  logic tick;
  logic inc;
  logic wrap;
  logic trig;
  logic ovf_set;
  logic exf_set;
  logic cap_load;
  logic reload;

  logic access;
  logic wr_en;
  logic wr_ctrl;
  logic wr_count;
  logic wr_cap;
  logic wr_ien;

  // ****************************************
  // Pin inputs
  // ****************************************
  tmc_fall_sync u_event_sync (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (event_pin_i),
    .fall_o    (ev_fall)
  );

  tmc_fall_sync u_trig_sync (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (trigger_input_pin_i),
    .fall_o    (trig_fall)
  );

  // ****************************************
  // APB decode
  // ****************************************
  // Zero wait states: every access completes in its first access cycle
  assign access   = apb_i.psel & apb_i.penable;
  assign wr_en    = access & apb_i.pwrite & tmc_pkg::tmc_is_mapped(apb_i.paddr);
  assign wr_ctrl  = wr_en & (apb_i.paddr == tmc_pkg::TMC_ADDR_CTRL);
  assign wr_count = wr_en & (apb_i.paddr == tmc_pkg::TMC_ADDR_COUNT);
  assign wr_cap   = wr_en & (apb_i.paddr == tmc_pkg::TMC_ADDR_CAP);
  assign wr_ien   = wr_en & (apb_i.paddr == tmc_pkg::TMC_ADDR_IEN);

  // ****************************************
  // Counting events
  // ****************************************
  assign mode     = tmc_pkg::tmc_mode(ctrl_q);
  assign tick     = ctrl_q.tcs ? ev_fall : 1'b1;
  assign inc      = (mode != tmc_pkg::TMC_OFF) & tick;
  assign wrap     = inc & (count_q == tmc_pkg::TMC_CNT_MAX);
  assign trig     = trig_fall & ctrl_q.ext_en & (mode != tmc_pkg::TMC_OFF);
  assign ovf_set  = wrap & ((mode == tmc_pkg::TMC_CAPTURE) | (mode == tmc_pkg::TMC_RELOAD));
  assign exf_set  = trig;
  assign cap_load = trig & (mode == tmc_pkg::TMC_CAPTURE);
  // Baud mode: trigger only flags, never reloads
  assign reload   = (wrap & ((mode == tmc_pkg::TMC_RELOAD) | (mode == tmc_pkg::TMC_BAUD)))
                  | (trig & (mode == tmc_pkg::TMC_RELOAD));

  // ****************************************
  // Counter
  // ****************************************
  // Software write wins over counting in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      count_q <= tmc_pkg::TMC_CNT_RST;
    end else if (wr_count) begin
      count_q <= apb_i.pwdata[15:0];
    end else if (reload) begin
      count_q <= cap_q;
    end else if (inc) begin
      count_q <= 16'(count_q + tmc_pkg::TMC_CNT_ONE);
    end
  end

  // ****************************************
  // Capture / reload register
  // ****************************************
  // A captured value beats a software write in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      cap_q <= tmc_pkg::TMC_CAP_RST;
    end else if (cap_load) begin
      cap_q <= count_q;
    end else if (wr_cap) begin
      cap_q <= apb_i.pwdata[15:0];
    end
  end

  // ****************************************
  // Control and flags
  // ****************************************
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = tmc_pkg::tmc_ctrl_t'(apb_i.pwdata[7:0]);
    end
    // Hardware set wins over a software clear
    ctrl_d.ovf = ctrl_d.ovf | ovf_set;
    ctrl_d.exf = ctrl_d.exf | exf_set;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ctrl_q <= tmc_pkg::TMC_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ien_q <= tmc_pkg::TMC_IEN_RST;
    end else if (wr_ien) begin
      ien_q <= apb_i.pwdata[tmc_pkg::TMC_IEN_BIT];
    end
  end

  // Not cleared on service: software must clear the flags itself
  assign irq_o = ien_q & (ctrl_q.ovf | ctrl_q.exf);

  // ****************************************
  // Read path
  // ****************************************
  // Read data captured in the setup cycle, so it lags live state by one cycle
  always_comb begin
    prdata_d = tmc_pkg::TMC_RDATA_RST;
    case (apb_i.paddr)
      tmc_pkg::TMC_ADDR_CTRL: begin
        prdata_d[7:0] = ctrl_q;
      end
      tmc_pkg::TMC_ADDR_COUNT: begin
        prdata_d[15:0] = count_q;
      end
      tmc_pkg::TMC_ADDR_CAP: begin
        prdata_d[15:0] = cap_q;
      end
      tmc_pkg::TMC_ADDR_IEN: begin
        prdata_d[tmc_pkg::TMC_IEN_BIT] = ien_q;
      end
      default: begin
        prdata_d = tmc_pkg::TMC_RDATA_RST;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      prdata_q <= tmc_pkg::TMC_RDATA_RST;
    end else if (apb_i.psel && !apb_i.penable && !apb_i.pwrite) begin
      prdata_q <= prdata_d;
    end
  end

  assign apb_o.pready  = access;
  assign apb_o.pslverr = access & ~tmc_pkg::tmc_is_mapped(apb_i.paddr);
  assign apb_o.prdata  = prdata_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_reloaded;
    ##1 (count_q == $past(cap_q));
  endsequence

  sequence s_captured;
    ##1 ((cap_q == $past(count_q)) && ctrl_q.exf);
  endsequence

  a_count_step_up: assert property (
    (inc && !reload && !wr_count && count_q != tmc_pkg::TMC_CNT_MAX) |=> (count_q == $past(count_q) + 16'h0001))
    else $error("counter did not step by one");

  a_off_holds_count: assert property (
    (!ctrl_q.run && !wr_count) |=> $stable(count_q))
    else $error("counter moved while stopped");

  a_capture_ovf_flag: assert property (
    (wrap && mode == tmc_pkg::TMC_CAPTURE) |=> (ctrl_q.ovf && count_q == 16'h0000) or $past(wr_count))
    else $error("capture mode overflow not flagged");

  a_irq_needs_enable: assert property (
    !ien_q |-> !irq_o)
    else $error("interrupt raised while disabled");

  a_capture_copy_count: assert property (
    (cap_load) |-> s_captured)
    else $error("trigger edge did not capture the count");

  a_trig_sets_event: assert property (
    (trig_fall && ctrl_q.ext_en && mode == tmc_pkg::TMC_CAPTURE) |=> ctrl_q.exf)
    else $error("trigger edge did not set event flag");

  a_irq_from_event: assert property (
    (ien_q && (ctrl_q.exf || ctrl_q.ovf)) |-> irq_o)
    else $error("flag set with enable but no interrupt");

  a_flags_sticky: assert property (
    (ctrl_q.ovf && !wr_ctrl) [*2] |=> ctrl_q.ovf)
    else $error("overflow flag dropped without software clear");

  a_event_sticky: assert property (
    (ctrl_q.exf && !wr_ctrl) |=> ctrl_q.exf)
    else $error("event flag dropped without software clear");

  a_reload_on_wrap: assert property (
    (wrap && mode == tmc_pkg::TMC_RELOAD && !wr_count) |-> s_reloaded ##0 ctrl_q.ovf)
    else $error("auto-reload overflow did not reload and flag");

  a_baud_no_ovf: assert property (
    (wrap && mode == tmc_pkg::TMC_BAUD && !wr_count && !wr_ctrl && !ctrl_q.ovf) |-> s_reloaded ##0 !ctrl_q.ovf)
    else $error("baud overflow flagged or did not reload");

endmodule

`default_nettype wire

/* File: bench/tmc_pin_src.sv */
// Partner model: counted event source and trigger pin
`default_nettype none
module tmc_pin_src (
  input  wire logic clk_i,
  output var  logic event_o,
  output var  logic trig_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    event_o = 1'b1;
    trig_o  = 1'b1;
  end
  // Low then high, each level held past the pin filter
  task automatic fall(input logic sel, input int len);
    for (int i = 0; i < 2 * len; i++) begin
      if (sel) trig_o <= (i >= len);
      else event_o <= (i >= len);
      @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_timer2_mode_select_capture.sv */
// Testbench: timer two modes, capture, reload, flags and APB access
`default_nettype none
module tb_timer2_mode_select_capture;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  sys_clk_i;
  logic                  rst_b_i;
  tmc_pkg::tmc_apb_req_t req;
  tmc_pkg::tmc_apb_rsp_t rsp;
  logic                  ev_pin;
  logic                  trig_pin;
  logic                  irq;
  int                    err_count;
  int                    comparisons;
  int                    cycles;
  int                    seed;
  logic [7:0]            mc;
  logic [15:0]           mcnt;
  logic [15:0]           mcap;
  logic                  mien;
  logic [31:0]           rd;
  logic                  er;
  logic [7:0]            modes [7] = '{8'h02, 8'h06, 8'h0E, 8'h07, 8'h0F, 8'h16, 8'h2E};

  tmc_timer2 i_tmc_timer2 (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .apb_i(req), .apb_o(rsp),
    .event_pin_i(ev_pin), .trigger_input_pin_i(trig_pin), .irq_o(irq));
  tmc_pin_src i_tmc_pin_src (.clk_i(sys_clk_i), .event_o(ev_pin), .trig_o(trig_pin));

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // Run is far shorter than this
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Errors %0d in %0d comparisons", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ****************************************
  // APB master, entered just after a rising edge
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge sys_clk_i);
    req.penable <= 1'b1;
    // Ends on pready; only the bench timeout bounds this wait
    do begin
      @(posedge sys_clk_i);
    end while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    // Idle edge, so a following call never re-drives psel in this time step
    @(posedge sys_clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, rd, er);
    chk_word(rd, exp);
  endtask

  // ****************************************
  // Reference model of counter, flags and capture
  // ****************************************
  function automatic void m_event();
    logic baud = mc[5] | mc[4];
    if (mc[2] && mc[1]) begin
      if (mcnt == 16'hFFFF) begin
        if (!baud) mc[7] = 1'b1;
        mcnt = (baud || !mc[0]) ? mcap : 16'h0000;
      end else mcnt = mcnt + 16'h0001;
    end
  endfunction

  function automatic void m_trig();
    logic baud = mc[5] | mc[4];
    if (mc[2] && mc[3]) begin
      mc[6] = 1'b1;
      if (!baud) begin
        if (mc[0]) mcap = mcnt;
        else mcnt = mcap;
      end
    end
  endfunction

  initial begin
    seed = 32'h0000_cce9;
    err_count = 0;
    comparisons = 0;
    cycles = 0;
    req = '0;
    rst_b_i = 1'b0;
    repeat (5) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    @(posedge sys_clk_i);
    for (int a = 0; a < 16; a += 4) rd_chk(a[7:0], 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000, rd, er);
    chk_bit(er, 1'b1);
    // Counted mode only, so the count is still between pin events
    for (int p = 0; p < 2; p++) begin
      mien = (p == 0);
      apb(1'b1, tmc_pkg::TMC_ADDR_IEN, {31'h0, mien}, rd, er);
      foreach (modes[k]) begin
        mcnt = (p == 0) ? 16'hFFFF : 16'($random(seed));
        mcap = 16'($random(seed));
        mc = modes[k];
        apb(1'b1, tmc_pkg::TMC_ADDR_COUNT, {16'h0000, mcnt}, rd, er);
        apb(1'b1, tmc_pkg::TMC_ADDR_CAP, {16'h0000, mcap}, rd, er);
        apb(1'b1, tmc_pkg::TMC_ADDR_CTRL, {24'h00_0000, mc}, rd, er);
        i_tmc_pin_src.fall(1'b0, 3 + p);
        m_event();
        i_tmc_pin_src.fall(1'b1, 4 - p);
        m_trig();
        rd_chk(tmc_pkg::TMC_ADDR_COUNT, {16'h0000, mcnt});
        rd_chk(tmc_pkg::TMC_ADDR_CAP, {16'h0000, mcap});
        rd_chk(tmc_pkg::TMC_ADDR_CTRL, {24'h00_0000, mc});
        chk_bit(irq, mien & (mc[7] | mc[6]));
      end
    end
    apb(1'b1, tmc_pkg::TMC_ADDR_COUNT, 32'h0000_FFF0, rd, er);
    apb(1'b1, tmc_pkg::TMC_ADDR_CTRL, 32'h0000_0005, rd, er);
    repeat (40) @(posedge sys_clk_i);
    rd_chk(tmc_pkg::TMC_ADDR_CTRL, 32'h0000_0085);
    chk_bit(irq, 1'b0);
    apb(1'b1, tmc_pkg::TMC_ADDR_IEN, 32'h0000_0001, rd, er);
    @(posedge sys_clk_i);
    chk_bit(irq, 1'b1);
    apb(1'b1, tmc_pkg::TMC_ADDR_CTRL, 32'h0000_0000, rd, er);
    rd_chk(tmc_pkg::TMC_ADDR_CTRL, 32'h0000_0000);
    chk_bit(irq, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
